// ### tb/testbench.sv
/*
 * Self-checking bench: terminal and host joined by the word link,
 * software side driven over APB, operator events driven directly.
 * Assumes default area bases and the package poll interval.
 */
`timescale 1ns/1ns
module testbench;
    import tses_pkg::*;
    logic clk_i, rst_b_i, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic op_screen_vld_i, screen_is_parent_i, touch_entry_vld_i;
    logic touch_is_numeral_i, show_group_o, host_switch_o, busy_o;
    logic [DW-1:0] op_screen_i, touch_entry_i, status_bits_i, disp_screen_o;
    logic [AW-1:0] nb;
    logic [11:0] bad_a [6] = '{12'h500, REG_STAT, REG_BASE, REG_BASE,
                               12'h042, 12'h040};
    logic [31:0] bad_d [6] = '{32'h0, 32'h1, 32'h1010, 32'h2004, 32'h0,
                               32'ha1};
    int n_errors = 0;
    int checks_done = 0;
    int cnt_sw, cnt_ent, cnt_busy;

    tses_link_if lk();
    tses_term u_tses_term (.clk_i(clk_i), .rst_b_i(rst_b_i), .lk(lk),
        .ctrl_base_i(CTRL_BASE_RST), .notify_base_i(NOTIFY_BASE_RST),
        .op_screen_vld_i(op_screen_vld_i), .op_screen_i(op_screen_i),
        .screen_is_parent_i(screen_is_parent_i),
        .touch_entry_vld_i(touch_entry_vld_i),
        .touch_is_numeral_i(touch_is_numeral_i),
        .touch_entry_i(touch_entry_i), .status_bits_i(status_bits_i),
        .disp_screen_o(disp_screen_o), .show_group_o(show_group_o),
        .host_switch_o(host_switch_o), .busy_o(busy_o));
    tses_host u_tses_host (.clk_i(clk_i), .rst_b_i(rst_b_i), .lk(lk),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    tses_monitor u_tses_monitor (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .req(lk.req), .we(lk.we), .addr(lk.addr), .wdata(lk.wdata),
        .ack(lk.ack), .rdata(lk.rdata));

    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp,
                       input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
            n_errors++;
        end
    endtask

    // Zero wait states are expected, but the wait stays open up to a bound
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge clk_i);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            n_errors++;
            close_out();
        end
    endtask

    // Terminal writes land late, so keep reading until the word settles
    task automatic mem_expect(input string nm, input logic [AW-1:0] w,
                              input logic [DW-1:0] exp);
        int i;
        for (i = 0; i < 40; i++) begin
            apb(1'b0, {2'b00, w, 2'b00}, 32'h0);
            if (rd[DW-1:0] === exp) break;
        end
        chk(nm, {16'h0000, exp}, rd);
        if (rd[DW-1:0] !== exp) begin
            close_out();
        end
    endtask

    task automatic op_switch(input logic [DW-1:0] s);
        @(posedge clk_i);
        op_screen_vld_i <= 1'b1;
        op_screen_i <= s;
        @(posedge clk_i);
        op_screen_vld_i <= 1'b0;
    endtask

    task automatic touch(input logic num, input logic [DW-1:0] e);
        @(posedge clk_i);
        touch_entry_vld_i <= 1'b1;
        touch_is_numeral_i <= num;
        touch_entry_i <= e;
        @(posedge clk_i);
        touch_entry_vld_i <= 1'b0;
    endtask

    task automatic watch(input int cyc);
        cnt_sw = 0;
        cnt_ent = 0;
        cnt_busy = 0;
        repeat (cyc) begin
            @(posedge clk_i);
            if (host_switch_o === 1'b1) cnt_sw++;
            if (busy_o !== lk.req) cnt_busy++;
            if (lk.req === 1'b1 && lk.we === 1'b1 && lk.addr === nb + 8'h01)
                cnt_ent++;
        end
    endtask

    task automatic wait_switch();
        int n;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (host_switch_o !== 1'b1 && n < 200);
        chk("host switch pulse", 32'h1, {31'h0, host_switch_o});
        if (host_switch_o !== 1'b1) begin
            close_out();
        end
    endtask

    initial begin
        nb = NOTIFY_BASE_RST;
        rst_b_i = 1'b0;
        {psel, penable, pwrite, op_screen_vld_i, screen_is_parent_i} = '0;
        {touch_entry_vld_i, touch_is_numeral_i} = '0;
        {paddr, pwdata, op_screen_i, touch_entry_i, status_bits_i} = '0;
        repeat (5) @(posedge clk_i);
        rst_b_i <= 1'b1;
        apb(1'b0, REG_CTL, 32'h0);
        chk("ctl reset", {30'h0, CTL_RST}, rd);
        apb(1'b0, REG_BASE, 32'h0);
        chk("base reset", {16'h0, nb, CTRL_BASE_RST}, rd);
        for (int i = 0; i < 6; i++) begin
            apb(1'b1, bad_a[i], bad_d[i]);
            chk("refused access", 32'h1, {31'h0, err});
        end
        apb(1'b0, REG_BASE, 32'h0);
        chk("base kept", {16'h0, nb, CTRL_BASE_RST}, rd);
        $display("registers test done");
        op_switch(16'h0012);
        mem_expect("current screen", nb, 16'h0012);
        mem_expect("setting copy", CTRL_BASE_RST, 16'h0012);
        mem_expect("status strobes", nb + 8'h02, 16'h0000);
        chk("disp screen", 32'h0012, {16'h0, disp_screen_o});
        $display("operator switch test done");
        touch(1'b1, 16'h0123);
        mem_expect("entry word", nb + 8'h01, 16'h0123);
        touch(1'b0, 16'h0456);
        watch(80);
        chk("string entry writes", 32'h0, cnt_ent);
        chk("busy follows request", 32'h0, cnt_busy);
        $display("touch test done");
        apb(1'b1, {2'b00, CTRL_BASE_RST, 2'b00}, 32'h0034);
        chk("bcd setting accepted", 32'h0, {31'h0, err});
        wait_switch();
        chk("disp after host", 32'h0034, {16'h0, disp_screen_o});
        mem_expect("host screen notify", nb, 16'h0034);
        apb(1'b1, {2'b00, CTRL_BASE_RST, 2'b00}, 32'h0034);
        watch(3 * POLL_CYC + 8);
        chk("same value switches", 32'h0, cnt_sw);
        apb(1'b1, {2'b00, CTRL_BASE_RST, 2'b00}, 32'h0000);
        watch(3 * POLL_CYC + 8);
        chk("blank value switches", 32'h0, cnt_sw);
        apb(1'b1, {2'b00, CTRL_BASE_RST, 2'b00}, 32'h0034);
        wait_switch();
        $display("host switch test done");
        apb(1'b1, REG_CTL, 32'h3);
        op_switch(16'h0056);
        mem_expect("async screen", nb, 16'h0056);
        watch(3 * POLL_CYC + 8);
        apb(1'b0, {2'b00, CTRL_BASE_RST, 2'b00}, 32'h0);
        chk("async no copy", 32'h0034, rd);
        $display("async host test done");
        @(posedge clk_i);
        status_bits_i <= 16'h1805;
        mem_expect("status bits", nb + 8'h02, 16'h0005);
        @(posedge clk_i);
        chk("group hidden", 32'h0, {31'h0, show_group_o});
        screen_is_parent_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        chk("group shown", 32'h1, {31'h0, show_group_o});
        $display("status and group test done");
        close_out();
    end
endmodule

// ### tb/tses_monitor.sv
/*
 * Concurrent checks on the word link between terminal and host memory.
 * Assumes the area bases left at their reset values and one clock
 * domain with an asynchronous active-low reset.
 */
`timescale 1ns/1ns
module tses_monitor
    import tses_pkg::*;
#(
    parameter logic [AW-1:0] NBASE = NOTIFY_BASE_RST,
    parameter logic [AW-1:0] CBASE = CTRL_BASE_RST
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic req,
    input wire logic we,
    input wire logic [AW-1:0] addr,
    input wire logic [DW-1:0] wdata,
    input wire logic ack,
    input wire logic [DW-1:0] rdata
);
    logic [AW-1:0] stat_addr;

    assign stat_addr = NBASE + 8'h02;

    default clocking dcb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);

    sequence wr_start(logic [AW-1:0] a);
        req && we && !ack && addr == a;
    endsequence

    sequence scr_strobe_wr;
        req && we && addr == stat_addr && wdata[BIT_SCR_STROBE];
    endsequence

    sequence num_strobe_wr;
        req && we && addr == stat_addr && wdata[BIT_NUM_STROBE];
    endsequence

    // Clearing write must carry neither strobe
    sequence clear_wr;
        req && we && addr == stat_addr && (wdata & STROBE_MASK) == 16'h0000;
    endsequence

    ack_answer_a: assert property (req && !ack |=> ack)
        else $error("link request not answered in the next cycle");
    req_hold_a: assert property (req && !ack |=> req && $stable(addr)
        && $stable(we) && $stable(wdata))
        else $error("link request changed before its answer");
    ack_pulse_a: assert property (ack |=> !ack)
        else $error("link answer longer than one cycle");
    screen_strobe_a: assert property (wr_start(NBASE) |=> ##[1:6]
        scr_strobe_wr)
        else $error("screen word write without screen strobe");
    numeral_strobe_a: assert property (wr_start(NBASE + 8'h01)
        |=> ##[1:6] num_strobe_wr)
        else $error("entry word write without numeral strobe");
    strobe_clear_a: assert property (req && we && !ack
        && addr == stat_addr && (wdata & STROBE_MASK) != 16'h0000
        |=> ##[1:4] clear_wr)
        else $error("strobe not cleared after its write");
    poll_addr_a: assert property (req && !we |-> addr == CBASE)
        else $error("terminal read outside the setting word");
    rdata_hold_a: assert property (!req |=> $stable(rdata))
        else $error("link read data changed with no request");
    write_area_a: assert property (req && we |-> addr >= NBASE
        && addr <= stat_addr)
        else $error("terminal write outside the notify area");
endmodule

// ### verilog/tses_host.sv
/*
 * Host controller end: a host memory reached by software over APB and by
 * the terminal over the word link, plus area placement checks and the
 * optional copy of the current screen into the setting word.
 * Assumes APB masters that keep the request stable until pready.
 */
`timescale 1ns/1ns
module tses_host #(
    parameter int MEM_WORDS = 256
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    tses_link_if.host lk,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    import tses_pkg::*;

    initial begin
        if (MEM_WORDS != 256) begin
            $error("MEM_WORDS must be 256 for an 8-bit word address");
        end
    end

    logic [DW-1:0] mem_q [MEM_WORDS];
    logic ack_q;
    logic [DW-1:0] rdata_q;
    logic [1:0] ctl_q;
    logic [AW-1:0] cbase_q, nbase_q;
    logic [7:0] copy_cnt_q;
    logic [31:0] prdata_q;
    logic acc, is_mem, wr_ok, bad, strobe_rise, copy;
    logic [AW-1:0] widx, nb, cb;

    function automatic logic is_bcd(input logic [DW-1:0] v);
        logic ok;
        ok = 1'b1;
        for (int i = 0; i < DW / 4; i++) begin
            if (v[i*4 +: 4] > 4'h9) begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction

    function automatic logic areas_ok(input logic [AW-1:0] c,
                                      input logic [AW-1:0] n);
        logic [AW:0] c9, n9;
        c9 = {1'b0, c};
        n9 = {1'b0, n};
        return c9 >= 9'(RSV_WORDS) && n9 >= 9'(RSV_WORDS)
            && c9 + 9'(CTRL_WORDS) <= 9'(MEM_WORDS)
            && n9 + 9'(NOTIFY_WORDS) <= 9'(MEM_WORDS)
            && (c9 + 9'(CTRL_WORDS) <= n9
                || n9 + 9'(NOTIFY_WORDS) <= c9);
    endfunction

    assign acc = psel && penable;
    assign is_mem = paddr < REG_CTL;
    assign widx = paddr[AW+1:2];
    assign nb = pwdata[15:8];
    assign cb = pwdata[7:0];
    always_comb begin
        bad = 1'b0;
        if (paddr[1:0] != 2'h0) begin
            bad = 1'b1;
        end else if (is_mem) begin
            // Screen numbers must be BCD in the setting word
            bad = pwrite && widx == cbase_q + OFS_SCR_SET
                  && !is_bcd(pwdata[DW-1:0]);
        end else if (paddr == REG_BASE) begin
            bad = pwrite && !areas_ok(cb, nb);
        end else if (paddr == REG_STAT) begin
            bad = pwrite;
        end else if (paddr != REG_CTL) begin
            bad = 1'b1;
        end
    end
    assign wr_ok = acc && pwrite && !bad;
    assign pready = 1'b1;
    assign pslverr = acc && bad;
    assign prdata = prdata_q;

    // Read data is fetched in the setup cycle, so the access cycle can
    // answer at once from a flop
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            prdata_q <= '0;
        end else if (psel && !penable) begin
            prdata_q <= '0;
            if (is_mem) begin
                prdata_q <= {16'h0000, mem_q[widx]};
            end else if (paddr == REG_CTL) begin
                prdata_q <= {30'h0, ctl_q};
            end else if (paddr == REG_BASE) begin
                prdata_q <= {16'h0000, nbase_q, cbase_q};
            end else if (paddr == REG_STAT) begin
                prdata_q <= {24'h0, copy_cnt_q};
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ctl_q <= CTL_RST;
            cbase_q <= CTRL_BASE_RST;
            nbase_q <= NOTIFY_BASE_RST;
        end else if (wr_ok && paddr == REG_CTL) begin
            ctl_q <= pwdata[1:0];
        end else if (wr_ok && paddr == REG_BASE) begin
            cbase_q <= cb;
            nbase_q <= nb;
        end
    end

    // Link request is taken on the edge that raises ack
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ack_q <= 1'b0;
            rdata_q <= '0;
        end else begin
            ack_q <= lk.req && !ack_q;
            if (lk.req && !ack_q) begin
                rdata_q <= mem_q[lk.addr];
            end
        end
    end

    // Copying is skipped for async hosts, where strobes are unreliable
    assign strobe_rise = lk.req && !ack_q && lk.we
        && lk.addr == nbase_q + OFS_STATUS && lk.wdata[BIT_SCR_STROBE]
        && !mem_q[nbase_q + OFS_STATUS][BIT_SCR_STROBE];
    assign copy = strobe_rise && ctl_q[CTL_COPY_BIT]
                  && !ctl_q[CTL_ASYNC_BIT];

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            copy_cnt_q <= 8'h00;
        end else if (copy) begin
            copy_cnt_q <= copy_cnt_q + 8'h01;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            for (int i = 0; i < MEM_WORDS; i++) begin
                mem_q[i] <= '0;
            end
        end else begin
            if (wr_ok && is_mem) begin
                mem_q[widx] <= pwdata[DW-1:0];
            end
            if (lk.req && !ack_q && lk.we) begin
                mem_q[lk.addr] <= lk.wdata;
            end
            if (copy) begin
                mem_q[cbase_q + OFS_SCR_SET] <=
                    mem_q[nbase_q + OFS_CUR_SCREEN];
            end
        end
    end

    assign lk.ack = ack_q;
    assign lk.rdata = rdata_q;
endmodule

// ### verilog/tses_link_if.sv
/*
 * Word link between the operator terminal (master) and the host memory
 * (slave). The terminal holds a request until ack is seen high.
 */
`timescale 1ns/1ns
interface tses_link_if;
    import tses_pkg::*;
    logic req;
    logic we;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic ack;
    logic [DW-1:0] rdata;

    modport term (output req, output we, output addr, output wdata,
                  input ack, input rdata);
    modport host (input req, input we, input addr, input wdata,
                  output ack, output rdata);
endinterface

// ### verilog/tses_pkg.sv
/*
 * Shared constants for the terminal status exchange: word layout of the
 * notify and control areas in host memory, strobe positions, host
 * register map and reset values.
 * Assumes 16-bit host memory words and a 250 MHz system clock.
 */
package tses_pkg;
    localparam int AW = 8;
    localparam int DW = 16;
    localparam int NOTIFY_WORDS = 3;
    localparam int CTRL_WORDS = 4;
    localparam logic [AW-1:0] OFS_CUR_SCREEN = 8'h00;
    localparam logic [AW-1:0] OFS_UPD_ENTRY = 8'h01;
    localparam logic [AW-1:0] OFS_STATUS = 8'h02;
    localparam logic [AW-1:0] OFS_SCR_SET = 8'h00;
    localparam int BIT_SCR_STROBE = 12;
    localparam int BIT_NUM_STROBE = 11;
    localparam logic [DW-1:0] STROBE_MASK = 16'h1800;
    localparam logic [DW-1:0] SCREEN_NONE = 16'h0000;
    localparam int POLL_CYC = 16;
    localparam logic [11:0] REG_CTL = 12'h400;
    localparam logic [11:0] REG_BASE = 12'h404;
    localparam logic [11:0] REG_STAT = 12'h408;
    localparam int CTL_COPY_BIT = 0;
    localparam int CTL_ASYNC_BIT = 1;
    localparam logic [1:0] CTL_RST = 2'h1;
    localparam logic [AW-1:0] CTRL_BASE_RST = 8'h10;
    localparam logic [AW-1:0] NOTIFY_BASE_RST = 8'h20;
    localparam int RSV_WORDS = 8;
endpackage

// ### verilog/tses_term.sv
/*
 * Operator terminal end of the status exchange. Writes the three-word
 * notify area into host memory and polls the host's screen-switch
 * setting word. Assumes the host answers every request on the link.
 */
// The implementer's own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
module tses_term #(
    parameter int POLL_CYCLES = tses_pkg::POLL_CYC
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    tses_link_if.term lk,
    input wire logic [tses_pkg::AW-1:0] ctrl_base_i,
    input wire logic [tses_pkg::AW-1:0] notify_base_i,
    input wire logic op_screen_vld_i,
    input wire logic [tses_pkg::DW-1:0] op_screen_i,
    input wire logic screen_is_parent_i,
    input wire logic touch_entry_vld_i,
    input wire logic touch_is_numeral_i,
    input wire logic [tses_pkg::DW-1:0] touch_entry_i,
    input wire logic [tses_pkg::DW-1:0] status_bits_i,
    output logic [tses_pkg::DW-1:0] disp_screen_o,
    output logic show_group_o,
    output logic host_switch_o,
    output logic busy_o
);
    import tses_pkg::*;

    initial begin
        if (POLL_CYCLES < 1 || POLL_CYCLES > 65535) begin
            $error("POLL_CYCLES out of range");
        end
    end

    typedef enum logic [5:0] {
        ST_IDLE = 6'b000001,
        ST_POLL = 6'b000010,
        ST_WSCR = 6'b000100,
        ST_WENT = 6'b001000,
        ST_WSTS = 6'b010000,
        ST_WCLR = 6'b100000
    } tses_state_e;

    tses_state_e state_q, state_d;
    logic [DW-1:0] cur_screen_q, entry_q, seen_q, sts_q;
    logic [DW-1:0] wdata_q;
    logic [AW-1:0] addr_q;
    logic we_q;
    logic pend_scr_q, pend_ent_q, pend_sts_q;
    logic strb_scr_q, strb_num_q, sent_scr_q, sent_num_q;
    logic show_group_q, host_switch_q;
    logic [15:0] poll_cnt_q;
    logic done, host_ev, scr_ev, num_ev, sts_ev, load;
    logic [DW-1:0] new_screen, sts_in;

    function automatic logic [DW-1:0] status_word(
        input logic [DW-1:0] bits, input logic s_scr, input logic s_num);
        logic [DW-1:0] w;
        w = bits & ~STROBE_MASK;
        w[BIT_SCR_STROBE] = s_scr;
        w[BIT_NUM_STROBE] = s_num;
        return w;
    endfunction

    assign done = lk.ack && state_q != ST_IDLE;
    // Only a change of the setting word switches; 0000 is a blank value
    assign host_ev = state_q == ST_POLL && lk.ack && lk.rdata != seen_q
                     && lk.rdata != SCREEN_NONE;
    assign scr_ev = host_ev || op_screen_vld_i;
    assign new_screen = host_ev ? lk.rdata : op_screen_i;
    assign num_ev = touch_entry_vld_i && touch_is_numeral_i;
    assign sts_in = status_word(status_bits_i, 1'b0, 1'b0);
    assign sts_ev = sts_in != sts_q;

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (pend_scr_q) begin
                    state_d = ST_WSCR;
                end else if (pend_ent_q) begin
                    state_d = ST_WENT;
                end else if (pend_sts_q) begin
                    state_d = ST_WSTS;
                end else if (poll_cnt_q == 16'h0000) begin
                    state_d = ST_POLL;
                end
            end
            ST_POLL, ST_WSCR, ST_WENT, ST_WCLR: begin
                if (done) begin
                    state_d = ST_IDLE;
                end
            end
            ST_WSTS: begin
                if (done) begin
                    state_d = (sent_scr_q || sent_num_q) ? ST_WCLR : ST_IDLE;
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    assign load = state_d != state_q && state_d != ST_IDLE;

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Transfer words are frozen when a request opens and held until ack
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            addr_q <= '0;
            wdata_q <= '0;
            we_q <= 1'b0;
            sent_scr_q <= 1'b0;
            sent_num_q <= 1'b0;
        end else if (load) begin
            we_q <= state_d != ST_POLL;
            sent_scr_q <= 1'b0;
            sent_num_q <= 1'b0;
            case (state_d)
                ST_POLL: addr_q <= ctrl_base_i + OFS_SCR_SET;
                ST_WSCR: begin
                    addr_q <= notify_base_i + OFS_CUR_SCREEN;
                    wdata_q <= cur_screen_q;
                end
                ST_WENT: begin
                    addr_q <= notify_base_i + OFS_UPD_ENTRY;
                    wdata_q <= entry_q;
                end
                ST_WSTS: begin
                    addr_q <= notify_base_i + OFS_STATUS;
                    wdata_q <= status_word(sts_q, strb_scr_q,
                                           strb_num_q);
                    sent_scr_q <= strb_scr_q;
                    sent_num_q <= strb_num_q;
                end
                ST_WCLR: begin
                    wdata_q <= status_word(sts_q, 1'b0, 1'b0);
                end
                default: addr_q <= addr_q;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            poll_cnt_q <= 16'h0000;
        end else if (state_q == ST_POLL) begin
            poll_cnt_q <= 16'(POLL_CYCLES - 1);
        end else if (state_q == ST_IDLE && poll_cnt_q != 16'h0000) begin
            poll_cnt_q <= poll_cnt_q - 16'h0001;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cur_screen_q <= SCREEN_NONE;
            seen_q <= SCREEN_NONE;
            host_switch_q <= 1'b0;
        end else begin
            host_switch_q <= host_ev;
            if (state_q == ST_POLL && lk.ack) begin
                seen_q <= lk.rdata;
            end
            if (scr_ev) begin
                cur_screen_q <= new_screen;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            entry_q <= '0;
            sts_q <= '0;
        end else begin
            sts_q <= sts_in;
            if (num_ev) begin
                entry_q <= touch_entry_i;
            end
        end
    end

    // A new event in the clearing cycle keeps its flag: set wins
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pend_scr_q <= 1'b0;
            pend_ent_q <= 1'b0;
            pend_sts_q <= 1'b0;
        end else begin
            pend_scr_q <= scr_ev || (pend_scr_q &&
                          !(state_q == ST_WSCR && done));
            pend_ent_q <= num_ev || (pend_ent_q &&
                          !(state_q == ST_WENT && done));
            pend_sts_q <= scr_ev || num_ev || sts_ev || (pend_sts_q &&
                          !(state_q == ST_WSTS && done));
        end
    end

    // Strobes drop only once the word carrying them has been taken;
    // the host still learns of changes from the words with async hosts
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            strb_scr_q <= 1'b0;
            strb_num_q <= 1'b0;
        end else begin
            if (scr_ev) begin
                strb_scr_q <= 1'b1;
            end else if (state_q == ST_WSTS && done && sent_scr_q) begin
                strb_scr_q <= 1'b0;
            end
            if (num_ev) begin
                strb_num_q <= 1'b1;
            end else if (state_q == ST_WSTS && done && sent_num_q) begin
                strb_num_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            show_group_q <= 1'b0;
        end else begin
            show_group_q <= screen_is_parent_i;
        end
    end

    assign lk.req = state_q != ST_IDLE;
    assign lk.we = we_q;
    assign lk.addr = addr_q;
    assign lk.wdata = wdata_q;
    assign disp_screen_o = cur_screen_q;
    assign show_group_o = show_group_q;
    assign host_switch_o = host_switch_q;
    assign busy_o = state_q != ST_IDLE;
endmodule
